//--- design/efs_pkg.sv
// Purpose: shared constants for the config / flag status block
// Assumes: all register access comes over the serial link
// Notes: opcodes are the device command bytes
// Notes on behaviour
// - Config bit 7 low selects four lines; high, the reset value, keeps one.
// - Config bit 6 low selects two lines; high, the reset value, keeps one.
// - Bits 7 and 6 both low give four lines; four beats two.
// - A new line mode starts only after its write command ends.
// - Config bit 4 high enables the hold/reset pin, low disables it.
// - Config bit 3 low enables supply boost for quad program.
// - Bits 2:0 hold drive strength, 111 at reset; 000, 100 reserved.
// - Config read/write commands work in every line mode.
// - Flag bit 7 is 0 while program or erase runs, else 1.
// - Ready bit ignores plain write command cycles.
// - Flag bit 6 shows erase suspend requested or in effect.
// - Flag bit 5 sets on erase failure or protection error; here only erase_fail_i sets it, protection errors set bit 1.
// - Flag bit 4 sets on program failure or 0-to-1 at high supply.
// - Flag bit 3 sets on bad boost supply during program or erase.
// - Flag bit 2 shows program suspend requested or in effect.
// - Flag bit 1 sets on protected sector or locked OTP target.
// - All flag bits are volatile and returned by flag read.
// - Ready and suspend bits follow operations without a clear.
// - Error bits stay set until the clear-flags command.
// - A command issued while an error is set reports an error.
// - Flag register may be read repeatedly, at any time.
package efs_pkg;
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_RD_EV  = 8'h65;
  localparam logic [7:0] OP_WR_EV  = 8'h61;
  localparam logic [7:0] OP_RD_FS  = 8'h70;
  localparam logic [7:0] OP_CLR_FS = 8'h50;
  localparam logic [7:0] EV_RST    = 8'hDF;
  localparam logic [7:0] EV_WMASK  = 8'hDF;
  localparam logic [7:0] FS_RST    = 8'h80;
  localparam logic [5:0] SYNC_RST  = 6'h10;
  localparam logic [2:0] DRV_RSV_A = 3'h0;
  localparam logic [2:0] DRV_RSV_B = 3'h4;
  localparam logic [3:0] W_SINGLE  = 4'h1;
  localparam logic [3:0] W_DUAL    = 4'h2;
  localparam logic [3:0] W_QUAD    = 4'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int EV_QUAD  = 7;
  localparam int EV_DUAL  = 6;
  localparam int EV_HOLD  = 4;
  localparam int EV_ACCEL = 3;
  localparam int FS_READY = 7;
  localparam int FS_ESUSP = 6;
  localparam int FS_PSUSP = 2;
  localparam int FS_PROT  = 1;
  typedef enum logic [1:0] {
    LN_SINGLE = 2'b00,
    LN_DUAL   = 2'b01,
    LN_QUAD   = 2'b10
  } efs_lanes_e;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_OPC   = 3'b001,
    ST_WDATA = 3'b010,
    ST_RDATA = 3'b011,
    ST_DONE  = 3'b100
  } efs_state_e;
endpackage

//--- design/efs_ser_if.sv
// Purpose: carrier between command control and serial shifter
// Assumes: all members live in the system clock domain
// Notes: link pins arrive here already synchronised
`timescale 1ns/10ps
interface efs_ser_if;
  import efs_pkg::*;
  logic       sck;
  logic       cs_n;
  logic [3:0] dq_in;
  efs_lanes_e lanes;
  logic       tx_en;
  logic [7:0] tx_byte;
  logic       frame_start;
  logic       frame_end;
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic [3:0] dq_out;
  logic [3:0] dq_oe;
  modport shf (input sck, cs_n, dq_in, lanes, tx_en, tx_byte,
               output frame_start, frame_end, rx_valid, rx_byte,
               dq_out, dq_oe);
  modport ctl (output sck, cs_n, dq_in, lanes, tx_en, tx_byte,
               input frame_start, frame_end, rx_valid, rx_byte,
               dq_out, dq_oe);
endinterface

//--- design/efs_ser_shift.sv
// Purpose: byte shifter for the serial link in 1, 2 or 4 line modes
// Assumes: sck, cs_n, dq already passed two flip-flops
// Notes: input taken on rising sck, output changed on falling sck
`timescale 1ns/10ps
module efs_ser_shift
  import efs_pkg::*;
(
  input  logic   clk_sys_i,
  input  logic   rstn_i,
  efs_ser_if.shf s
);
  logic       sck_q;
  logic       cs_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [3:0] rcnt_q;
  logic [3:0] tcnt_q;
  wire        rise   = s.sck & ~sck_q & ~s.cs_n;
  wire        fall   = ~s.sck & sck_q & ~s.cs_n;
  wire        quad   = (s.lanes == LN_QUAD);
  wire        dual   = (s.lanes == LN_DUAL);
  wire  [3:0] w      = quad ? W_QUAD : (dual ? W_DUAL : W_SINGLE);
  wire  [3:0] rsum   = rcnt_q + w;
  wire  [7:0] rx_d   = quad ? {rx_q[3:0], s.dq_in} :
                       dual ? {rx_q[5:0], s.dq_in[1:0]} :
                              {rx_q[6:0], s.dq_in[0]};
  // Fresh byte fetched each boundary so repeated reads see live state
  wire  [7:0] tx_src = (tcnt_q == 4'h0) ? s.tx_byte : tx_q;
  wire  [3:0] nib    = quad ? tx_src[7:4] :
                       dual ? {2'h0, tx_src[7:6]} :
                              {2'h0, tx_src[7], 1'b0};
  wire  [3:0] mask   = quad ? 4'hF : (dual ? 4'h3 : 4'h2);
  wire  [3:0] tbase  = (tcnt_q == 4'h0) ? BYTE_BITS : tcnt_q;

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sck_q         <= 1'b0;
      cs_q          <= 1'b1;
      s.frame_start <= 1'b0;
      s.frame_end   <= 1'b0;
      s.rx_valid    <= 1'b0;
      s.rx_byte     <= 8'h00;
      s.dq_out      <= 4'h0;
      s.dq_oe       <= 4'h0;
      rx_q          <= 8'h00;
      tx_q          <= 8'h00;
      rcnt_q        <= 4'h0;
      tcnt_q        <= 4'h0;
    end
    else
    begin
      sck_q         <= s.sck;
      cs_q          <= s.cs_n;
      s.frame_start <= cs_q & ~s.cs_n;
      s.frame_end   <= ~cs_q & s.cs_n;
      s.rx_valid    <= rise && (rsum == BYTE_BITS);
      s.dq_oe       <= (s.tx_en && !s.cs_n) ? mask : 4'h0;
      if (rise)
      begin
        rx_q   <= rx_d;
        rcnt_q <= (rsum == BYTE_BITS) ? 4'h0 : rsum;
      end
      else if (s.cs_n)
        rcnt_q <= 4'h0;
      if (rise && rsum == BYTE_BITS)
        s.rx_byte <= rx_d;
      if (s.cs_n)
        tcnt_q <= 4'h0;
      else if (fall && s.tx_en)
      begin
        s.dq_out <= nib;
        tx_q     <= tx_src << w;
        tcnt_q   <= tbase - w;
      end
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  a_oe_width: assert property (
    (s.tx_en && !s.cs_n && s.lanes == LN_SINGLE) |=> s.dq_oe == 4'h2)
    else $error("single line read drives wrong pins");
endmodule

//--- design/efs_cfg_flag_top.sv
// Purpose: enhanced volatile config and flag status register logic
// Assumes: program/erase events come from same-clock logic
// Notes: serial pins are synchronised before any use
`timescale 1ns/10ps
module efs_cfg_flag_top
  import efs_pkg::*;
(
  input  logic       clk_sys_i,
  input  logic       rstn_i,
  input  logic       sck_i,
  input  logic       cs_n_i,
  input  logic [3:0] dq_i,
  output logic [3:0] dq_o,
  output logic [3:0] dq_oe_o,
  input  logic       pe_busy_i,
  input  logic       erase_susp_i,
  input  logic       prog_susp_i,
  input  logic       erase_fail_i,
  input  logic       prog_fail_i,
  input  logic       zero_to_one_i,
  input  logic       accel_supply_high_level_i,
  input  logic       pattern_x64_i,
  input  logic       accel_invalid_i,
  input  logic       prot_sector_i,
  input  logic       otp_locked_i,
  input  logic       pe_cmd_i,
  output logic       quad_mode_o,
  output logic       dual_mode_o,
  output logic       hold_reset_en_o,
  output logic       accel_prog_en_o,
  output logic [2:0] drv_strength_o,
  output logic       wr_enable_o,
  output logic       err_pending_o,
  output logic [7:0] flag_status_o
);
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  efs_state_e st_q;
  efs_state_e st_d;
  efs_lanes_e lanes_q;
  logic [7:0] evcr_q;
  logic [7:0] fsr_q;
  logic [7:0] ev_data_q;
  logic       wel_q;
  logic       wren_p_q;
  logic       wrdi_p_q;
  logic       clr_p_q;
  logic       ev_p_q;
  logic       rd_fs_q;

  efs_ser_if sif ();

  efs_ser_shift u_shift (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .s         (sif.shf)
  );

  // Two stages per pin; only the second stage is looked at
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end
    else
    begin
      sync1_q <= {sck_i, cs_n_i, dq_i};
      sync2_q <= sync1_q;
    end
  end

  assign sif.sck     = sync2_q[5];
  assign sif.cs_n    = sync2_q[4];
  assign sif.dq_in   = sync2_q[3:0];
  assign sif.lanes   = lanes_q;
  assign sif.tx_en   = (st_q == ST_RDATA);
  assign sif.tx_byte = rd_fs_q ? fsr_q : evcr_q;
  assign dq_o        = sif.dq_out;
  assign dq_oe_o     = sif.dq_oe;
  assign flag_status_o = fsr_q;

  // Opcode decode is the same in every line mode
  wire [7:0] op      = sif.rx_byte;
  wire       opc_hit = sif.rx_valid && (st_q == ST_OPC);
  wire       wdat_hit = sif.rx_valid && (st_q == ST_WDATA);
  wire       fend    = sif.frame_end;
  wire       is_wren = opc_hit && (op == OP_WREN);
  wire       is_wrdi = opc_hit && (op == OP_WRDI);
  wire       is_clr  = opc_hit && (op == OP_CLR_FS);
  wire       is_rdfs = opc_hit && (op == OP_RD_FS);

  // Config write lands only when the frame closes and WEL was set
  wire       ev_commit = fend && ev_p_q && wel_q;
  wire       clr_now   = fend && clr_p_q;
  wire [2:0] drv_wr    = ev_data_q[2:0];
  // Reserved strength codes would leave the pad undefined: keep old
  wire       drv_ok    = (drv_wr != DRV_RSV_A) &&
                         (drv_wr != DRV_RSV_B);
  wire [7:0] ev_new    = {ev_data_q[7:3],
                          drv_ok ? drv_wr : evcr_q[2:0]} & EV_WMASK;
  wire [7:0] evcr_d    = ev_commit ? ev_new : evcr_q;

  // Quad wins when both select bits are low
  wire efs_lanes_e lanes_d = !evcr_q[EV_QUAD] ? LN_QUAD :
                             !evcr_q[EV_DUAL] ? LN_DUAL :
                             LN_SINGLE;

  wire       wel_d = !fend    ? wel_q :
                     wren_p_q ? 1'b1 :
                     (wrdi_p_q || ev_p_q) ? 1'b0 : wel_q;

  // Error bits in order: erase, program, supply, protection
  wire [3:0] err_q   = {fsr_q[5], fsr_q[4], fsr_q[3], fsr_q[FS_PROT]};
  wire       prog_z1 = zero_to_one_i & accel_supply_high_level_i &
                       pattern_x64_i;
  wire       late_cmd = pe_cmd_i & (|err_q);
  wire [3:0] err_set = {erase_fail_i,
                        prog_fail_i | prog_z1,
                        accel_invalid_i,
                        prot_sector_i | otp_locked_i | late_cmd};
  // Set wins over a clear landing in the same cycle
  wire [3:0] err_d   = (err_q & ~{4{clr_now}}) | err_set;

  // Busy input covers only program/erase style cycles, not WREN
  wire [7:0] fsr_d   = {~pe_busy_i,
                        erase_susp_i,
                        err_d[3],
                        err_d[2],
                        err_d[1],
                        prog_susp_i,
                        err_d[0],
                        1'b0};

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:
        if (sif.frame_start)
          st_d = ST_OPC;
      ST_OPC:
        if (sif.rx_valid)
        begin
          case (op)
            OP_WR_EV: st_d = ST_WDATA;
            OP_RD_EV: st_d = ST_RDATA;
            OP_RD_FS: st_d = ST_RDATA;
            default:  st_d = ST_DONE;
          endcase
        end
      ST_WDATA:
        if (sif.rx_valid)
          st_d = ST_DONE;
      ST_RDATA: st_d = ST_RDATA;
      ST_DONE:  st_d = ST_DONE;
      default:  st_d = ST_IDLE;
    endcase
    if (fend)
      st_d = ST_IDLE;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_q    <= ST_IDLE;
      lanes_q <= LN_SINGLE;
      evcr_q  <= EV_RST;
      fsr_q   <= FS_RST;
      wel_q   <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      lanes_q <= lanes_d;
      evcr_q  <= evcr_d;
      fsr_q   <= fsr_d;
      wel_q   <= wel_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wren_p_q  <= 1'b0;
      wrdi_p_q  <= 1'b0;
      clr_p_q   <= 1'b0;
      ev_p_q    <= 1'b0;
      rd_fs_q   <= 1'b0;
      ev_data_q <= 8'h00;
    end
    else
    begin
      wren_p_q <= !fend && (wren_p_q || is_wren);
      wrdi_p_q <= !fend && (wrdi_p_q || is_wrdi);
      clr_p_q  <= !fend && (clr_p_q || is_clr);
      ev_p_q   <= !fend && (ev_p_q || wdat_hit);
      if (opc_hit)
        rd_fs_q <= is_rdfs;
      if (wdat_hit)
        ev_data_q <= sif.rx_byte;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      quad_mode_o     <= ~EV_RST[EV_QUAD];
      dual_mode_o     <= EV_RST[EV_QUAD] & ~EV_RST[EV_DUAL];
      hold_reset_en_o <= EV_RST[EV_HOLD];
      accel_prog_en_o <= ~EV_RST[EV_ACCEL];
      drv_strength_o  <= EV_RST[2:0];
      wr_enable_o     <= 1'b0;
      err_pending_o   <= 1'b0;
    end
    else
    begin
      quad_mode_o     <= (lanes_q == LN_QUAD);
      dual_mode_o     <= (lanes_q == LN_DUAL);
      hold_reset_en_o <= evcr_q[EV_HOLD];
      accel_prog_en_o <= ~evcr_q[EV_ACCEL];
      drv_strength_o  <= evcr_q[2:0];
      wr_enable_o     <= wel_q;
      err_pending_o   <= |err_q;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  a_quad_select: assert property (
    !evcr_q[EV_QUAD] ##1 $stable(evcr_q) |-> lanes_q == LN_QUAD)
    else $error("quad select not applied");

  a_dual_select: assert property (
    (evcr_q[EV_QUAD] && !evcr_q[EV_DUAL]) ##1 $stable(evcr_q)
      |-> lanes_q == LN_DUAL)
    else $error("dual select not applied");

  a_single_mode: assert property (
    (evcr_q[EV_QUAD] && evcr_q[EV_DUAL]) ##1 $stable(evcr_q)
      |-> lanes_q == LN_SINGLE)
    else $error("single line mode not kept");

  a_mode_in_frame: assert property (
    (st_q != ST_IDLE) ##1 (st_q != ST_IDLE) |-> $stable(lanes_q))
    else $error("line mode changed inside a command");

  a_hold_follow: assert property (
    $changed(evcr_q[EV_HOLD]) |=> ##1
      hold_reset_en_o == $past(evcr_q[EV_HOLD], 2))
    else $error("hold enable output lags config");

  a_accel_follow: assert property (
    $rose(evcr_q[EV_ACCEL]) |=> !accel_prog_en_o)
    else $error("boost enable not dropped");

  a_cfg_write: assert property (
    (fend && ev_p_q && wel_q)
      |=> evcr_q[7:3] == ($past(ev_data_q[7:3]) & EV_WMASK[7:3]))
    else $error("config write lost");

  a_cfg_no_wel: assert property (
    (fend && !wel_q) |=> $stable(evcr_q))
    else $error("config changed without write enable");

  a_drv_rsvd: assert property (
    (ev_commit && !drv_ok) |=> $stable(evcr_q[2:0]))
    else $error("reserved strength code stored");

  a_ready_bit: assert property (
    pe_busy_i ##1 pe_busy_i |-> !fsr_q[FS_READY] ##1 !fsr_q[FS_READY])
    else $error("ready bit shows ready while busy");

  a_esusp_bit: assert property (
    erase_susp_i |=> fsr_q[FS_ESUSP])
    else $error("erase suspend not shown");

  a_psusp_bit: assert property (
    !prog_susp_i |=> !fsr_q[FS_PSUSP])
    else $error("program suspend not cleared");

  a_erase_err: assert property (
    erase_fail_i |=> fsr_q[5])
    else $error("erase error not set");

  a_prog_err: assert property (
    (zero_to_one_i && accel_supply_high_level_i && pattern_x64_i)
      |=> fsr_q[4])
    else $error("program error not set");

  a_supply_err: assert property (
    accel_invalid_i |=> fsr_q[3])
    else $error("supply error not set");

  a_prot_err: assert property (
    (prot_sector_i || otp_locked_i) |=> fsr_q[FS_PROT])
    else $error("protection error not set");

  a_err_sticky: assert property (
    (|err_q && !clr_now)
      |=> (err_q & $past(err_q)) == $past(err_q))
    else $error("error bit dropped without clear");

  a_err_clear: assert property (
    (clr_now && err_set == 4'h0) |=> err_q == 4'h0 ##1 1'b1)
    else $error("clear flags did not clear");

  a_late_cmd: assert property (
    (pe_cmd_i && |err_q) |=> fsr_q[FS_PROT] ##1 err_pending_o)
    else $error("command over pending error not reported");

  a_rsvd_zero: assert property (
    !fsr_q[0] && !evcr_q[5])
    else $error("reserved bit reads one");

  c_quad_entry: cover property (ev_commit && !ev_new[EV_QUAD]);
  c_fsr_read: cover property (is_rdfs ##[1:200] sif.dq_oe != 4'h0);
  c_err_clear: cover property (|err_q ##1 clr_now);
  c_dual_read: cover property (lanes_q == LN_DUAL && sif.tx_en);
endmodule

//--- testbench/efs_host_model.sv
// Purpose: serial host that sends command frames to the flash block
// Assumes: mode 0 link, sck half period of five system clocks (40 ns)
// Notes: unused data lines toggle every beat so stale levels never match
`timescale 1ns/10ps
module efs_host_model
(
  input  wire logic       clk_sys_i,
  input  wire logic [3:0] dq_i,
  output logic            sck_o,
  output logic            cs_n_o,
  output logic [3:0]      dq_o
);
  initial
  begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    dq_o   = 4'h5;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // One byte over w lines, MSB first; returns what the device sent back
  task automatic xfer(input logic [7:0] tx, input int w,
                      output logic [7:0] rx);
    logic [7:0] sh;
    sh = tx;
    rx = 8'h00;
    for (int n = 0; n < 8 / w; n++)
    begin
      dq_o = ~dq_o;
      for (int b = 0; b < w; b++)
        dq_o[b] = sh[8 - w + b];
      tick(4);
      sck_o = 1'b1;
      rx = (rx << w) | {4'h0, (w == 1) ? {3'h0, dq_i[1]}
                                       : dq_i & (4'hF >> (4 - w))};
      tick(5);
      sck_o = 1'b0;
      sh = sh << w;
      tick(1);
    end
  endtask

  // Opcode, then nb bytes of dat; rd holds the last byte read back
  task automatic frame(input logic [7:0] op, input logic [7:0] dat,
                       input int nb, input int w,
                       output logic [7:0] rd);
    cs_n_o = 1'b0;
    tick(5);
    xfer(op, w, rd);
    for (int i = 0; i < nb; i++)
      xfer(dat, w, rd);
    tick(2);
    cs_n_o = 1'b1;
    // Gap covers the frame-end delay and the mode update after it
    tick(12);
  endtask
endmodule

//--- testbench/testbench.sv
// Purpose: self-checking bench for the config and flag status block
// Assumes: host model drives the serial link, bench drives the events
// Notes: every expectation is worked out here from the register layout
`timescale 1ns/10ps
module testbench;
  import efs_pkg::*;
  logic       clk;
  logic       rstn;
  logic       sck;
  logic       cs_n;
  logic [3:0] dq_host;
  logic [3:0] dq_dev;
  logic [3:0] dq_oe;
  wire  [3:0] dq_w;
  logic       busy;
  logic       esusp;
  logic       psusp;
  logic       er_fail;
  logic       pg_fail;
  logic       z_to_one;
  logic       sup_bad;
  logic       prot_hit;
  logic       otp_hit;
  logic       pe_cmd;
  logic       hi;
  logic       x64;
  logic       quad;
  logic       dual;
  logic       hold;
  logic       accel;
  logic [2:0] drv;
  logic       wel;
  logic       errp;
  logic [7:0] fsr;
  wire  [7:0] outs;
  logic [7:0] r;
  logic [7:0] v;
  logic [7:0] e;
  logic [2:0] d;
  int         w;
  int         fail_count;
  int         check_count;
  logic [7:0] modes [4] = '{8'h9F, 8'h1F, 8'h5F, 8'hDF};
  logic [7:0] errs [6] = '{8'h20, 8'h10, 8'h10, 8'h08, 8'h02, 8'h02};

  // Device drives a pin only while its enable is set; the host drives it otherwise
  assign dq_w = (dq_oe & dq_dev) | (~dq_oe & dq_host);
  assign outs = {quad, dual, hold, accel, drv, wel};

  efs_host_model host (.clk_sys_i(clk), .dq_i(dq_w), .sck_o(sck),
                       .cs_n_o(cs_n), .dq_o(dq_host));

  efs_cfg_flag_top dut (.clk_sys_i(clk), .rstn_i(rstn), .sck_i(sck),
    .cs_n_i(cs_n), .dq_i(dq_w), .dq_o(dq_dev), .dq_oe_o(dq_oe),
    .pe_busy_i(busy), .erase_susp_i(esusp), .prog_susp_i(psusp),
    .erase_fail_i(er_fail), .prog_fail_i(pg_fail),
    .zero_to_one_i(z_to_one),
    .accel_supply_high_level_i(hi), .pattern_x64_i(x64),
    .accel_invalid_i(sup_bad), .prot_sector_i(prot_hit),
    .otp_locked_i(otp_hit), .pe_cmd_i(pe_cmd), .quad_mode_o(quad),
    .dual_mode_o(dual), .hold_reset_en_o(hold),
    .accel_prog_en_o(accel), .drv_strength_o(drv),
    .wr_enable_o(wel), .err_pending_o(errp), .flag_status_o(fsr));

  always #4 clk = ~clk;

  function automatic logic [7:0] exp_out(input logic [7:0] c);
    return {~c[7], c[7] & ~c[6], c[4], ~c[3], c[2:0], 1'b0};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic rd(input logic [7:0] op, input int lw);
    host.frame(op, 8'h00, 1, lw, r);
  endtask

  task automatic wr_cfg(input logic [7:0] c, input int lw);
    host.frame(OP_WREN, 8'h00, 0, lw, r);
    host.frame(OP_WR_EV, c, 1, lw, r);
  endtask

  // Each event input has its own driver so every one can be exercised
  task automatic drive_ev(input int k, input logic v);
    case (k)
      0: er_fail = v;
      1: pg_fail = v;
      2: z_to_one = v;
      3: sup_bad = v;
      4: prot_hit = v;
      5: otp_hit = v;
      default: pe_cmd = v;
    endcase
  endtask

  task automatic pulse(input int k);
    drive_ev(k, 1'b1);
    host.tick(1);
    drive_ev(k, 1'b0);
    host.tick(3);
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    busy = 1'b0;
    esusp = 1'b0;
    psusp = 1'b0;
    hi = 1'b0;
    x64 = 1'b0;
    for (int k = 0; k < 7; k++)
      drive_ev(k, 1'b0);
    fail_count = 0;
    check_count = 0;
    host.tick(5);
    rstn = 1'b1;
    host.tick(3);
    check(fsr, FS_RST);
    check(outs, 8'h2E);
    rd(OP_RD_EV, 1);
    check(r, EV_RST);
    // Write refused without the enable latch, and after it is dropped
    host.frame(OP_WR_EV, 8'h00, 1, 1, r);
    host.frame(OP_WREN, 8'h00, 0, 1, r);
    check(wel, 1'b1);
    host.frame(OP_WRDI, 8'h00, 0, 1, r);
    check(wel, 1'b0);
    host.frame(OP_WR_EV, 8'h00, 1, 1, r);
    host.frame(8'hAA, 8'h00, 1, 1, r);
    rd(OP_RD_EV, 1);
    check(r, EV_RST);
    d = 3'h7;
    for (int c = 0; c < 8; c++)
    begin
      v = {3'b111, c[0], ~c[0], 3'(c)};
      if (c != 0 && c != 4)
        d = 3'(c);
      e = {3'b110, c[0], ~c[0], d};
      wr_cfg(v, 1);
      rd(OP_RD_EV, 1);
      check(r, e);
      check(outs, exp_out(e));
      check(fsr, FS_RST);
    end
    w = 1;
    for (int i = 0; i < 4; i++)
    begin
      wr_cfg(modes[i], w);
      w = !modes[i][7] ? 4 : !modes[i][6] ? 2 : 1;
      check(outs, exp_out(modes[i]));
      rd(OP_RD_EV, w);
      check(r, modes[i]);
      rd(OP_RD_FS, w);
      check(r, FS_RST);
      check({4'h0, dq_oe}, 8'h00);
    end
    busy = 1'b1;
    host.tick(2);
    check(fsr, 8'h00);
    rd(OP_RD_FS, 1);
    check(r, 8'h00);
    busy = 1'b0;
    esusp = 1'b1;
    host.tick(2);
    check(fsr, 8'hC0);
    psusp = 1'b1;
    host.tick(2);
    check(fsr, 8'hC4);
    esusp = 1'b0;
    psusp = 1'b0;
    host.tick(2);
    check(fsr, FS_RST);
    hi = 1'b1;
    x64 = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      pulse(i);
      host.tick(20);
      check(fsr, FS_RST | errs[i]);
      check(errp, 1'b1);
      rd(OP_RD_FS, 1);
      check(r, FS_RST | errs[i]);
      host.frame(OP_CLR_FS, 8'h00, 0, 1, r);
      check(fsr, FS_RST);
    end
    // A 0-to-1 attempt needs both high supply and a 64-bit pattern
    x64 = 1'b0;
    pulse(2);
    check(fsr, FS_RST);
    x64 = 1'b1;
    hi = 1'b0;
    pulse(2);
    check(fsr, FS_RST);
    pulse(6);
    check(fsr, FS_RST);
    pulse(1);
    pulse(6);
    check(fsr, 8'h92);
    host.frame(OP_CLR_FS, 8'h00, 0, 1, r);
    check({errp, fsr[6:0]}, 8'h00);
    end_of_test();
  end
endmodule
